// file: core/ppc_defs.svh
// Purpose: Constants of the pushbutton and serial wiper control block
// Assumes: Core clock of 40 MHz
// Notes:   Times are kept in their own unit; cycle counts are derived
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define PPC_CLK_KHZ       32'h0000_9c40
`define PPC_PRESS_MIN_MS  32'h0000_0001
`define PPC_MS_CYC        (`PPC_PRESS_MIN_MS * `PPC_CLK_KHZ)
`define PPC_HOLD_MS       10'h3e8
`define PPC_IDLE_MS       10'h3e8
`define PPC_REP_MS        7'h64
`define PPC_DEB_TICKS     2'h2
`define PPC_STRAP_WAIT    3'h4
`define PPC_COMMIT_WAIT   3'h4

// -----------------------------------------------------------------------------
// Setting register layout and reset values
// -----------------------------------------------------------------------------
`define PPC_SETTING_W     16
`define PPC_POS_W         6
`define PPC_POS_TOP       6'h00
`define PPC_POS_BOTTOM    6'h3f
`define PPC_MUTE_LEVEL    7'h40
`define PPC_SETTING_RESET 16'h3f3f

`endif

// file: core/ppc_pkg.sv
// Purpose: Types of the pushbutton and serial wiper control block
// Assumes: Field widths are written out, not taken from ppc_defs.svh
// Notes:   Setting layout matches the 16-bit shift register
package ppc_pkg;

  // One pot byte: top bit ignored, then mute, then position
  typedef struct packed {
    logic       spare;
    logic       mute;
    logic [5:0] pos;
  } ppc_pot_s;

  // Pot1 in the high byte, pot0 in the low byte
  typedef struct packed {
    ppc_pot_s pot1;
    ppc_pot_s pot0;
  } ppc_setting_s;

  // Contact configuration fixed at power-up
  typedef enum logic [1:0] {
    PPC_IND_DUAL,
    PPC_IND_SINGLE,
    PPC_STE_DUAL,
    PPC_STE_SINGLE
  } ppc_mode_e;

endpackage : ppc_pkg

// file: core/ppc_top.sv
// Purpose: Pushbutton and 3-wire serial control of two wiper positions
// Assumes: Contact and serial pins are asynchronous to core_clk_in
// Notes:   Serial shift logic runs on ser_clk_in, the rest on core_clk_in
`include "ppc_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module ppc_top #(
  parameter logic [15:0] CYC_PER_MS = 16'(`PPC_MS_CYC),
  parameter logic [9:0]  HOLD_MS    = `PPC_HOLD_MS,
  parameter logic [9:0]  IDLE_MS    = `PPC_IDLE_MS,
  parameter logic [6:0]  REP_MS     = `PPC_REP_MS
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       mode_in,
  input  wire logic [3:0] contact_n_in,
  input  wire logic       ser_clk_in,
  input  wire logic       xfer_en_in,
  input  wire logic       ser_data_in,
  output logic            cascade_out,
  output logic [6:0]      wiper0_out,
  output logic [6:0]      wiper1_out
);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  // One step toward the high end (up) or low end, saturating at the ends
  function automatic logic [5:0] ppc_move(input logic [5:0] p, input logic up);
    if (up) begin
      ppc_move = (p == `PPC_POS_TOP) ? p : p - 6'h01;
    end else begin
      ppc_move = (p == `PPC_POS_BOTTOM) ? p : p + 6'h01;
    end
  endfunction : ppc_move

  function automatic logic ppc_at_end(input logic [5:0] p, input logic up);
    ppc_at_end = up ? (p == `PPC_POS_TOP) : (p == `PPC_POS_BOTTOM);
  endfunction : ppc_at_end

  // Balance toward the favoured wiper: {favoured, other}
  function automatic logic [11:0] ppc_bal(input logic [5:0] fav, input logic [5:0] oth);
    if (fav > oth) begin
      ppc_bal = {fav - 6'h01, oth};
    end else begin
      ppc_bal = {fav, ppc_move(oth, 1'b0)};
    end
  endfunction : ppc_bal

  // ---------------------------------------------------------------------------
  // Serial link domain
  // ---------------------------------------------------------------------------
  ppc_pkg::ppc_setting_s set_q, set_d;
  logic [15:0]           sr_q, sr_d;
  logic                  tog_q, tog_d;
  logic                  first_q;
  logic                  frame_rst_n;

  // First edge of a frame loads from the live setting, later edges shift sr_q on
  always_comb begin
    tog_d = tog_q;
    sr_d  = sr_q;
    if (xfer_en_in) begin
      sr_d  = {ser_data_in, (first_q ? sr_q[15:1] : set_q[15:1])};
      tog_d = first_q ? tog_q : ~tog_q;  // One flip per frame, so an even edge count still commits
    end
  end

  always_ff @(posedge ser_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sr_q  <= `PPC_SETTING_RESET;
      tog_q <= 1'b0;
    end else begin
      sr_q  <= sr_d;
      tog_q <= tog_d;
    end
  end

  // Ended by the frame itself since the serial clock may stop between frames
  assign frame_rst_n = rst_n_in & xfer_en_in;

  always_ff @(posedge ser_clk_in or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      first_q <= 1'b0;
    end else begin
      first_q <= 1'b1;
    end
  end

  // Setting is frozen while a frame is open, so it is quasi-static here
  assign cascade_out = first_q ? sr_q[0] : set_q[0];

  // ---------------------------------------------------------------------------
  // Synchronisers and millisecond tick
  // ---------------------------------------------------------------------------
  logic [3:0]  c1_q, c2_q, c3_q;
  logic [2:0]  x1_q, x2_q, x3_q;  // 0 select, 1 toggle, 2 mode
  logic [15:0] pre_q, pre_d;
  logic        tick;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      c1_q <= 4'hf;
      c2_q <= 4'hf;
      c3_q <= 4'hf;
      x1_q <= 3'h0;
      x2_q <= 3'h0;
      x3_q <= 3'h0;
    end else begin
      c1_q <= contact_n_in;
      c2_q <= c1_q;
      c3_q <= c2_q;
      x1_q <= {mode_in, tog_q, xfer_en_in};
      x2_q <= x1_q;
      x3_q <= x2_q;
    end
  end

  assign tick  = (pre_q == CYC_PER_MS - 16'h0001);
  assign pre_d = tick ? 16'h0000 : pre_q + 16'h0001;

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_q <= 16'h0000;
    end else begin
      pre_q <= pre_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Press engines, one per contact pin
  // ---------------------------------------------------------------------------
  logic [3:0] deb_q, deb_d, fall, step, long_idle;
  logic [3:0] used_q, used_d;
  logic [1:0] stab_q [4];
  logic [1:0] stab_d [4];
  logic [9:0] hold_q [4];
  logic [9:0] hold_d [4];
  logic [9:0] idle_q [4];
  logic [9:0] idle_d [4];
  logic [6:0] rep_q  [4];
  logic [6:0] rep_d  [4];

  // Debounce needs two whole ticks of a new level, so gaps under 1 ms merge
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      deb_d[i]     = deb_q[i];
      used_d[i]    = used_q[i];
      stab_d[i]    = stab_q[i];
      hold_d[i]    = hold_q[i];
      idle_d[i]    = idle_q[i];
      rep_d[i]     = rep_q[i];
      step[i]      = 1'b0;
      long_idle[i] = (idle_q[i] == IDLE_MS);
      if ((c2_q[i] == c3_q[i]) && (c3_q[i] != deb_q[i])) begin
        if (tick) begin
          stab_d[i] = stab_q[i] + 2'h1;
          if (stab_q[i] == `PPC_DEB_TICKS - 2'h1) begin
            deb_d[i]  = c3_q[i];
            stab_d[i] = 2'h0;
          end
        end
      end else if (c2_q[i] == c3_q[i]) begin
        stab_d[i] = 2'h0;
      end
      fall[i] = deb_q[i] & ~deb_d[i];
      if (fall[i]) begin
        step[i]   = 1'b1;
        used_d[i] = 1'b1;
        hold_d[i] = 10'h000;
        rep_d[i]  = 7'h00;
        idle_d[i] = 10'h000;
      end else if (!deb_q[i] && tick) begin
        if (hold_q[i] != HOLD_MS) begin
          hold_d[i] = hold_q[i] + 10'h001;
          step[i]   = (hold_d[i] == HOLD_MS);
        end else begin
          rep_d[i] = rep_q[i] + 7'h01;
          if (rep_d[i] == REP_MS) begin
            step[i]  = 1'b1;
            rep_d[i] = 7'h00;
          end
        end
      // Idle time runs only after a first press, so power-up direction and channel hold
      end else if (deb_q[i] && used_q[i] && tick && !long_idle[i]) begin
        idle_d[i] = idle_q[i] + 10'h001;
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      deb_q <= 4'hf;
      used_q <= 4'h0;
      for (int i = 0; i < 4; i++) begin
        stab_q[i] <= 2'h0;
        hold_q[i] <= 10'h000;
        idle_q[i] <= 10'h000;
        rep_q[i]  <= 7'h00;
      end
    end else begin
      deb_q <= deb_d;
      used_q <= used_d;
      for (int i = 0; i < 4; i++) begin
        stab_q[i] <= stab_d[i];
        hold_q[i] <= hold_d[i];
        idle_q[i] <= idle_d[i];
        rep_q[i]  <= rep_d[i];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Power-up strap, frame tracking and wiper actions
  // ---------------------------------------------------------------------------
  ppc_pkg::ppc_mode_e mode_q, mode_d;
  logic [2:0]         strap_q, strap_d;
  logic               done_q, done_d;
  logic               sel_q, sel_d;
  logic               base_q, base_d;
  logic [2:0]         pend_q, pend_d;
  logic [1:0]         dir_q, dir_d;
  logic               bal_q, bal_d;
  logic [6:0]         w0_q, w0_d, w1_q, w1_d;
  logic [5:0]         pp [2];
  logic               busy, d, b;

  always_comb begin
    mode_d  = mode_q;
    strap_d = strap_q;
    done_d  = done_q;
    sel_d   = sel_q;
    base_d  = base_q;
    pend_d  = pend_q;
    dir_d   = dir_q;
    bal_d   = bal_q;
    set_d   = set_q;
    d       = 1'b0;
    b       = 1'b0;
    // Strap waits until the synchronisers hold settled pin levels
    if (!done_q) begin
      strap_d = strap_q + 3'h1;
      if (strap_q == `PPC_STRAP_WAIT) begin
        done_d = 1'b1;
        if (x3_q[2]) begin
          mode_d = (c3_q[2] & c3_q[3]) ? ppc_pkg::PPC_IND_SINGLE
                                       : ppc_pkg::PPC_IND_DUAL;
        end else begin
          mode_d = (c3_q[2] & c3_q[3]) ? ppc_pkg::PPC_STE_SINGLE
                                       : ppc_pkg::PPC_STE_DUAL;
        end
      end
    end
    // Select level and frame end; commit waits for the toggle to settle
    if (x2_q[0] == x3_q[0]) begin
      sel_d = x3_q[0];
      if (x3_q[0] && !sel_q) begin
        base_d = x3_q[1];
      end
      if (!x3_q[0] && sel_q) begin
        pend_d = `PPC_COMMIT_WAIT;
      end
    end
    if (pend_q != 3'h0) begin
      pend_d = pend_q - 3'h1;
      if ((pend_q == 3'h1) && (x3_q[1] != base_q)) begin
        set_d = ppc_pkg::ppc_setting_s'(sr_q);
      end
    end
    busy  = sel_q | (pend_q != 3'h0) | !done_q;
    pp[0] = set_q.pot0.pos;
    pp[1] = set_q.pot1.pos;
    if (!busy) begin
      case (mode_q)
        ppc_pkg::PPC_IND_DUAL: begin
          for (int k = 0; k < 2; k++) begin
            if (step[k]) begin
              pp[k] = ppc_move(pp[k], 1'b1);
            end
            if (step[k+2]) begin
              pp[k] = ppc_move(pp[k], 1'b0);
            end
          end
        end
        ppc_pkg::PPC_IND_SINGLE: begin
          for (int k = 0; k < 2; k++) begin
            if (step[k]) begin
              d = dir_q[k];
              if (fall[k] && long_idle[k]) begin
                d = ~d;
              end
              if (ppc_at_end(pp[k], d)) begin
                d = ~d;
              end
              pp[k]    = ppc_move(pp[k], d);
              dir_d[k] = d;
            end
          end
        end
        ppc_pkg::PPC_STE_DUAL: begin
          if (step[0] && !ppc_at_end(pp[0], 1'b1) && !ppc_at_end(pp[1], 1'b1)) begin
            pp[0] = pp[0] - 6'h01;
            pp[1] = pp[1] - 6'h01;
          end
          if (step[2] && !ppc_at_end(pp[0], 1'b0) && !ppc_at_end(pp[1], 1'b0)) begin
            pp[0] = pp[0] + 6'h01;
            pp[1] = pp[1] + 6'h01;
          end
          if (step[1]) begin
            {pp[0], pp[1]} = ppc_bal(pp[0], pp[1]);
          end
          if (step[3]) begin
            {pp[1], pp[0]} = ppc_bal(pp[1], pp[0]);
          end
        end
        ppc_pkg::PPC_STE_SINGLE: begin
          if (step[0]) begin
            d = dir_q[0];
            if (fall[0] && long_idle[0]) begin
              d = ~d;
            end
            if (ppc_at_end(pp[0], d) || ppc_at_end(pp[1], d)) begin
              d = ~d;
            end
            if (!ppc_at_end(pp[0], d) && !ppc_at_end(pp[1], d)) begin
              pp[0] = ppc_move(pp[0], d);
              pp[1] = ppc_move(pp[1], d);
            end
            dir_d[0] = d;
          end
          if (step[1]) begin
            b = bal_q;
            if (fall[1] && long_idle[1]) begin
              b = ~b;
            end
            if (b) begin
              {pp[1], pp[0]} = ppc_bal(pp[1], pp[0]);
            end else begin
              {pp[0], pp[1]} = ppc_bal(pp[0], pp[1]);
            end
            bal_d = b;
          end
        end
        default: begin
          dir_d = dir_q;
        end
      endcase
      set_d.pot0.pos = pp[0];
      set_d.pot1.pos = pp[1];
    end
    // Mute overrides the position field
    w0_d = set_d.pot0.mute ? `PPC_MUTE_LEVEL : {1'b0, set_d.pot0.pos};
    w1_d = set_d.pot1.mute ? `PPC_MUTE_LEVEL : {1'b0, set_d.pot1.pos};
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_q  <= ppc_pkg::PPC_IND_DUAL;
      strap_q <= 3'h0;
      done_q  <= 1'b0;
      sel_q   <= 1'b0;
      base_q  <= 1'b0;
      pend_q  <= 3'h0;
      dir_q   <= 2'h3;
      bal_q   <= 1'b0;
      set_q   <= `PPC_SETTING_RESET;
      w0_q    <= {1'b0, `PPC_POS_BOTTOM};
      w1_q    <= {1'b0, `PPC_POS_BOTTOM};
    end else begin
      mode_q  <= mode_d;
      strap_q <= strap_d;
      done_q  <= done_d;
      sel_q   <= sel_d;
      base_q  <= base_d;
      pend_q  <= pend_d;
      dir_q   <= dir_d;
      bal_q   <= bal_d;
      set_q   <= set_d;
      w0_q    <= w0_d;
      w1_q    <= w1_d;
    end
  end

  assign wiper0_out = w0_q;
  assign wiper1_out = w1_q;

endmodule : ppc_top

`default_nettype wire

// file: verif/ppc_host_model.sv
// Purpose: Host side of the 3-wire link for ppc_top
// Assumes: Link clock of 80 ns, made only inside frames
// Notes:   Idle clock and select sit low; data flips after a frame ends
`timescale 1ns/1ps
`default_nettype none

module ppc_host_model (
  input  wire logic cascade_in,
  output logic      ser_clk_out,
  output logic      xfer_en_out,
  output logic      ser_data_out
);
  // All output pins start low; the data line is not forced low again between frames
  initial begin
    ser_clk_out  = 1'b0;
    xfer_en_out  = 1'b0;
    ser_data_out = 1'b0;
  end

  // ---------------------------------------------
  // Frame: sixteen clocks, loop feeds cascade back
  // ---------------------------------------------
  task automatic frame(input logic [15:0] val, input logic loop, output logic [15:0] seen);
    int i;
    xfer_en_out = 1'b1;
    #80;
    for (i = 0; i < 16; i++) begin
      ser_data_out = loop ? cascade_in : val[i];
      seen[i] = cascade_in;
      #40 ser_clk_out = 1'b1;
      #40 ser_clk_out = 1'b0;
    end
    #40 xfer_en_out = 1'b0;
    // Released line must not keep showing the last bit
    ser_data_out = ~ser_data_out;
    #1000;
  endtask : frame
endmodule : ppc_host_model
`default_nettype wire

// file: verif/ppc_top_chk.sv
// Purpose: Port assertions for ppc_top
// Assumes: Core clock domain only
// Notes:   Helper counters saturate
`timescale 1ns/1ps
`default_nettype none

module ppc_top_chk #(
  parameter logic [15:0] CYC_PER_MS = 16'h0004
) (
  input wire logic       core_clk_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] contact_n_in,
  input wire logic       xfer_en_in,
  input wire logic       cascade_out,
  input wire logic [6:0] wiper0_out,
  input wire logic [6:0] wiper1_out
);
  default clocking dc @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  logic [4:0]  quiet_q, quiet_d;
  logic [15:0] low_q, low_d;
  logic        high_q, high_d;

  // Age of select low; length of the newest contact low run
  always_comb begin
    quiet_d = xfer_en_in ? 5'h00 : quiet_q + 5'(quiet_q != 5'h1f);
    high_d  = &contact_n_in;
    low_d   = high_d ? low_q : (high_q ? 16'h0001 : low_q + 16'(low_q != 16'hffff));
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      quiet_q <= 5'h00;
      low_q   <= 16'h0000;
      high_q  <= 1'b1;
    end else begin
      quiet_q <= quiet_d;
      low_q   <= low_d;
      high_q  <= high_d;
    end
  end

  // ---------------------------------------------
  // Assertions
  // ---------------------------------------------
  reset_low_end_a:
    assert property ($rose(rst_n_in) |-> wiper0_out == 7'h3f && wiper1_out == 7'h3f)
      else $error("wiper not at 63 after reset");
  wiper_range_a:
    assert property (wiper0_out <= 7'h40 && wiper1_out <= 7'h40) else $error("wiper beyond mute level");
  strap_quiet_a:
    assert property ($rose(rst_n_in) |-> ($stable(wiper0_out) && $stable(wiper1_out))[*4])
      else $error("wiper moved before strap");
  frame_hold_a:
    assert property (xfer_en_in[*6] |-> $stable(wiper0_out) && $stable(wiper1_out))
      else $error("wiper moved inside a frame");
  commit_wait_a:
    assert property ($fell(xfer_en_in) |-> ##1 ($stable(wiper0_out) && $stable(wiper1_out))[*6])
      else $error("commit too early");
  step_one_a:
    assert property (quiet_q == 5'h1f && $changed(wiper0_out) && $past(wiper0_out) != 7'h40
      |-> wiper0_out == $past(wiper0_out) + 7'h01 || wiper0_out + 7'h01 == $past(wiper0_out))
      else $error("button step not one position");
  press_min_a:
    assert property (quiet_q == 5'h1f && ($changed(wiper0_out) || $changed(wiper1_out))
      |-> low_q >= CYC_PER_MS) else $error("step without a full press");
  cascade_idle_a:
    assert property (quiet_q == 5'h1f && $stable(wiper0_out) && wiper0_out != 7'h40
      |-> cascade_out == wiper0_out[0]) else $error("cascade not setting bit 0");

  cover property ($fell(xfer_en_in));
  cover property (quiet_q == 5'h1f && $changed(wiper1_out));
  cover property (wiper1_out == 7'h40);
endmodule : ppc_top_chk
`default_nettype wire

// file: verif/ppc_top_tb.sv
// Purpose: Self-checking bench for ppc_top
// Assumes: 1 ms shortened to 4 core cycles
// Notes:   Four power-ups cover the contact modes
`timescale 1ns/1ps
`default_nettype none

module ppc_top_tb;
  localparam logic [15:0] CYC_PER_MS = 16'h0004;
  logic       core_clk, rst_n, mode, sclk, xen, sdata, casc;
  logic [3:0] cont_n;
  logic [6:0] w0, w1;
  logic [15:0] seen;
  int         n_fail, total_checks;

  // Hold and repeat differ so a mix-up shows as a wrong count
  ppc_top #(.CYC_PER_MS(CYC_PER_MS), .HOLD_MS(10'h014), .IDLE_MS(10'h00a), .REP_MS(7'h0a)) i_dut (
    .core_clk_in(core_clk), .rst_n_in(rst_n), .mode_in(mode), .contact_n_in(cont_n),
    .ser_clk_in(sclk), .xfer_en_in(xen), .ser_data_in(sdata), .cascade_out(casc),
    .wiper0_out(w0), .wiper1_out(w1));
  ppc_host_model i_host (.cascade_in(casc), .ser_clk_out(sclk), .xfer_en_out(xen), .ser_data_out(sdata));

  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wchk(input logic [6:0] e0, input logic [6:0] e1);
    chk({2'h0, w1, w0}, {2'h0, e1, e0});
  endtask : wchk
  task automatic test_done;
    $display("checks=%0d fails=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : cyc
  // Gap after release stays under the idle time
  task automatic press(input int pin, input int n);
    cont_n[pin] = 1'b0;
    cyc(n);
    cont_n[pin] = 1'b1;
    cyc(24);
  endtask : press
  task automatic restart(input logic m, input logic [3:0] c);
    rst_n  = 1'b0;
    mode   = m;
    cont_n = c;
    cyc(5);
    rst_n = 1'b1;
    cyc(12);
    cont_n = 4'hf;
    cyc(12);
    wchk(7'h3f, 7'h3f);
  endtask : restart

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // Watchdog against a hung run
  initial begin
    #400000;
    n_fail++;
    test_done();
  end

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial begin
    n_fail = 0;
    total_checks = 0;
    rst_n = 1'b0;
    mode = 1'b1;
    cont_n = 4'hf;
    // Independent dual: a lower contact low at the strap
    restart(1'b1, 4'h7);
    press(0, 12); wchk(7'h3e, 7'h3f);
    press(0, 2); wchk(7'h3e, 7'h3f);
    press(2, 12); wchk(7'h3f, 7'h3f);
    press(2, 12); wchk(7'h3f, 7'h3f);
    cont_n[1] = 1'b0;
    cyc(12);
    cont_n[1] = 1'b1;
    cyc(2);
    press(1, 12); wchk(7'h3f, 7'h3e);
    press(0, 150); wchk(7'h3c, 7'h3e);
    i_host.frame(16'h4595, 1'b0, seen);
    wchk(7'h15, 7'h40);
    i_host.frame(16'h0000, 1'b1, seen);
    chk(seen, 16'h4595);
    wchk(7'h15, 7'h40);
    // Independent single: one contact, both ways
    restart(1'b1, 4'hf);
    press(0, 12); wchk(7'h3e, 7'h3f);
    press(0, 12); wchk(7'h3d, 7'h3f);
    cyc(48);
    press(0, 12); wchk(7'h3e, 7'h3f);
    press(0, 12); wchk(7'h3f, 7'h3f);
    press(0, 12); wchk(7'h3e, 7'h3f);
    // Stereo single: volume then balance
    restart(1'b0, 4'hf);
    press(0, 12); wchk(7'h3e, 7'h3e);
    press(1, 12); wchk(7'h3e, 7'h3f);
    cyc(48);
    press(1, 12); wchk(7'h3e, 7'h3e);
    // Stereo dual: a balance-second contact low at the strap
    restart(1'b0, 4'h7);
    press(0, 12); wchk(7'h3e, 7'h3e);
    press(3, 12); wchk(7'h3f, 7'h3e);
    press(1, 12); wchk(7'h3e, 7'h3e);
    press(2, 12); wchk(7'h3f, 7'h3f);
    press(2, 12); wchk(7'h3f, 7'h3f);
    test_done();
  end
endmodule : ppc_top_tb

bind ppc_top ppc_top_chk #(.CYC_PER_MS(CYC_PER_MS)) i_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .contact_n_in(contact_n_in), .xfer_en_in(xfer_en_in),
  .cascade_out(cascade_out), .wiper0_out(wiper0_out), .wiper1_out(wiper1_out));
`default_nettype wire
